// >>> src/loop_opts.v
// option logic of a two-channel inductive loop detector
// Operation
// R01: green compensation desensitizes 0.05 percent over 15 s during green with call
// R02: compensation off means normal compensation only; enable held per channel
// R03: count display replaces normal display with channel vehicle count
// R04: per channel 16-bit vehicle counter wraps from 65535 to zero
// R05: display low three digits up to 999, else alternate upper and lower
// R06: counter reset off-to-on clears that channel's count
// R07: counter reset setting always reads back as off when viewed
// R08: lane loop setting per channel, five values one through five
// R09: common fail makes any channel failure drive both fail outputs
// R10: third-car mode calls both channels only while both loops occupied
// R11: third-car first detecting channel shows pending while waiting
// R12: directional first detecting channel is pending, outputs no call
// R13: directional last detecting channel calls until its own detection ends
// R14: directional first channel runs no timers, behaves as presence
// R15: directional second channel runs its programmed timing normally
// R16: audible follows selected channel raw occupancy only
// R17: audible enabled on one channel clears it on the other
// R18: audible setting clears itself after 15 minutes and at reset
// R19: disconnect in green: detection end starts extension, expiry withholds calls
// R20: disconnect with green inactive gives normal behaviour
// R21: subtype off: extension still applies and serves as disconnect timer
// R22: subtype on: no extension, call follows occupancy until disconnect
// R23: extension 0 to 25.5 s in 0.1 s steps, restarts on re-entry
// R24: controller drives phase green low for green, high for not green
// R25: count each detected vehicle exactly once
// R26: paired modes exclusive on channels one and two; pending clears properly
`timescale 1ns/100ps
`include "loop_opts_map.vh"
module loop_opts #(
  parameter TICK_CYCLES = `TICK_CYCLES,
  parameter AUD_TICKS = `AUD_TICKS
) (
  // clock, reset, enable
  input wire mclk_i,
  input wire nrst_i,
  input wire ce_i,
  // register port
  input wire [3:0] addr_i,
  input wire [15:0] wdata_i,
  input wire wr_i,
  input wire rd_i,
  output reg [15:0] rdata_o,
  // detector core, same clock
  input wire [1:0] occ_i,
  input wire [1:0] fail_i,
  // controller pins
  input wire [1:0] green_n_i,
  output wire [1:0] call_o,
  output wire [1:0] fail_o,
  // front panel
  output wire [1:0] pending_o,
  output wire audible_o,
  output reg [15:0] comp_o
);

////////////////////////////////////////////////////////////////////////////////
// synchronisers and tick

reg [1:0] gs1_q;
reg [1:0] gs2_q;
reg [26:0] tick_cnt_q;
// one shared 0.1 s tick: timers quantise to it, so a first step may come early
wire tick = (tick_cnt_q == TICK_CYCLES - 1);
always @(posedge mclk_i)
begin
  if (!nrst_i)
  begin
    gs1_q <= 2'h3;
    gs2_q <= 2'h3;
    tick_cnt_q <= 27'h0;
  end
  else if (ce_i)
  begin
    gs1_q <= green_n_i;
    gs2_q <= gs1_q;
    tick_cnt_q <= tick ? 27'h0 : tick_cnt_q + 27'h1;
  end
end
wire [1:0] green = ~gs2_q; // R24

////////////////////////////////////////////////////////////////////////////////
// settings

reg [2:0] ctrl_q;
reg [10:0] cfg_q [0:1];
reg [7:0] ext_q [0:1];
reg [22:0] aud_cnt_q;
wire wr_cfg0 = wr_i && addr_i == `REG_CH0_CFG;
wire wr_cfg1 = wr_i && addr_i == `REG_CH1_CFG;
wire aud_exp = (aud_cnt_q == AUD_TICKS - 1) && tick;
// paired modes are exclusive; directional wins if both written
wire dir_mode = ctrl_q[`CTRL_DIRECTIONAL]; // R26
wire tcp_mode = ctrl_q[`CTRL_THIRD_CAR] && !dir_mode; // R26

always @(posedge mclk_i)
begin
  if (!nrst_i)
  begin
    ctrl_q <= 3'h0;
    cfg_q[0] <= {`LANE_RESET, 8'h00};
    cfg_q[1] <= {`LANE_RESET, 8'h00};
    ext_q[0] <= 8'h00;
    ext_q[1] <= 8'h00;
    aud_cnt_q <= 23'h0; // R18
  end
  else if (ce_i)
  begin
    if (wr_i && addr_i == `REG_CTRL)
      ctrl_q <= wdata_i[2:0];
    if (wr_i && addr_i == `REG_CH0_EXT)
      ext_q[0] <= wdata_i[7:0]; // R23
    if (wr_i && addr_i == `REG_CH1_EXT)
      ext_q[1] <= wdata_i[7:0];
    if (wr_cfg0)
      cfg_q[0] <= {(wdata_i[10:8] >= 3'h1 && wdata_i[10:8] <= `LANE_MAX) ?
        wdata_i[10:8] : cfg_q[0][10:8], 2'h0, wdata_i[5:0]}; // R08
    if (wr_cfg1)
      cfg_q[1] <= {(wdata_i[10:8] >= 3'h1 && wdata_i[10:8] <= `LANE_MAX) ?
        wdata_i[10:8] : cfg_q[1][10:8], 2'h0, wdata_i[5:0]};
    // counter reset bit never stays set, so it always reads off
    if (!wr_cfg0)
      cfg_q[0][`CFG_CNT_RST] <= 1'b0; // R07
    if (!wr_cfg1)
      cfg_q[1][`CFG_CNT_RST] <= 1'b0;
    // audible exclusivity and timeout
    if (wr_cfg0 && wdata_i[`CFG_AUDIBLE])
      cfg_q[1][`CFG_AUDIBLE] <= 1'b0; // R17
    else if (wr_cfg1 && wdata_i[`CFG_AUDIBLE])
      cfg_q[0][`CFG_AUDIBLE] <= 1'b0; // R17
    if ((wr_cfg0 || wr_cfg1) && wdata_i[`CFG_AUDIBLE])
      aud_cnt_q <= 23'h0;
    else if (aud_exp)
    begin
      if (!wr_cfg0)
        cfg_q[0][`CFG_AUDIBLE] <= 1'b0; // R18
      if (!wr_cfg1)
        cfg_q[1][`CFG_AUDIBLE] <= 1'b0; // R18
      aud_cnt_q <= 23'h0;
    end
    else if (tick && (cfg_q[0][`CFG_AUDIBLE] || cfg_q[1][`CFG_AUDIBLE]))
      aud_cnt_q <= aud_cnt_q + 23'h1;
  end
end

assign audible_o = (cfg_q[0][`CFG_AUDIBLE] && occ_i[0]) ||
  (cfg_q[1][`CFG_AUDIBLE] && occ_i[1]); // R16

////////////////////////////////////////////////////////////////////////////////
// pairing: who detected first

reg [1:0] first_q;
reg [1:0] occ_prev_q;
// first_q names the channel that detected first; one-hot codes let it mask calls
localparam [1:0] PAIR_IDLE = 2'h0;
localparam [1:0] PAIR_FIRST0 = 2'h1;
localparam [1:0] PAIR_FIRST1 = 2'h2;
wire paired = dir_mode || tcp_mode;
always @(posedge mclk_i)
begin
  if (!nrst_i)
  begin
    first_q <= 2'h0;
    occ_prev_q <= 2'h0;
  end
  else if (ce_i)
  begin
    occ_prev_q <= occ_i;
    case (first_q)
      PAIR_IDLE:
      begin
        if (paired && occ_i == 2'h2)
          first_q <= PAIR_FIRST1;
        else if (paired && occ_i != 2'h0)
          first_q <= PAIR_FIRST0; // both at once: channel one taken as first
      end
      PAIR_FIRST0, PAIR_FIRST1:
      begin
        if (!paired || occ_i == 2'h0)
          first_q <= PAIR_IDLE; // R26
        else if (occ_i != 2'h3 && (first_q & occ_i) == 2'h0 && !dir_mode)
          first_q <= occ_i; // third-car: the loop still occupied waits again
        // directional keeps the first even after it leaves: the last keeps calling
      end
      default:
        first_q <= PAIR_IDLE;
    endcase
  end
end
// pending while first alone; clears once both detect
assign pending_o = (paired && occ_i != 2'h3 && (first_q & occ_i) != 2'h0) ?
  first_q : 2'h0; // R11 R12 R26

////////////////////////////////////////////////////////////////////////////////
// per channel timing, counting and display

wire [1:0] base_call;
wire [1:0] any_fail = ctrl_q[`CTRL_COMMON_FAIL] && (fail_i != 2'h0) ?
  2'h3 : fail_i;
assign fail_o = any_fail; // R09
// each channel owns its state; these packed buses only carry it out
wire [31:0] cnt_all;
wire [31:0] disp_all;
wire [31:0] comp_all;
wire [15:0] cnt_view0 = cnt_all[15:0];
wire [15:0] cnt_view1 = cnt_all[31:16];
wire [15:0] disp_view0 = disp_all[15:0];
wire [15:0] disp_view1 = disp_all[31:16];
wire [15:0] comp_view0 = comp_all[15:0];
wire [15:0] comp_view1 = comp_all[31:16];
// the ramp product is kept in 24 bits: 500 times 150 steps needs 17, overflowing 16
localparam [23:0] COMP_DIV = `COMP_TICKS;

genvar c;
generate
  for (c = 0; c < 2; c = c + 1)
  begin : g_ch
    reg [7:0] ext_cnt_q;
    reg ext_run_q;
    reg disc_q;
    reg [7:0] comp_tick_q;
    reg [3:0] alt_q;
    reg alt_hi_q;
    reg [15:0] cnt_q;
    reg [15:0] disp_q;
    reg [15:0] comp_q;
    wire [10:0] cfg = cfg_q[c];
    // directional first channel: no timers, plain presence
    wire no_timers = dir_mode && first_q[c]; // R14
    wire disc_act = cfg[`CFG_DISC_EN] && green[c] && !no_timers; // R19 R20
    wire use_ext = !no_timers && !(disc_act && cfg[`CFG_DISC_SUB]); // R15 R21 R22
    wire fall = occ_prev_q[c] && !occ_i[c];
    wire rise = occ_i[c] && !occ_prev_q[c];
    // the stored reset bit clears a cycle after its write, so a write with it set is an off-to-on change unless the previous cycle also set it
    wire cnt_rst = (c == 0 ? wr_cfg0 : wr_cfg1) && wdata_i[`CFG_CNT_RST] &&
      !cfg[`CFG_CNT_RST];
    wire [15:0] lo3 = cnt_q % 16'h03e8;
    wire [15:0] hi2 = cnt_q / 16'h03e8;
    wire [23:0] comp_num = {8'h00, `COMP_TOTAL} * {16'h0000, comp_tick_q + 8'h01};
    wire [23:0] comp_quo = comp_num / COMP_DIV;
    always @(posedge mclk_i)
    begin
      if (!nrst_i)
      begin
        ext_cnt_q <= 8'h00;
        ext_run_q <= 1'b0;
        disc_q <= 1'b0;
        cnt_q <= 16'h0000;
        disp_q <= 16'h0000;
        comp_q <= 16'h0000;
        comp_tick_q <= 8'h00;
        alt_q <= 4'h0;
        alt_hi_q <= 1'b0;
      end
      else if (ce_i)
      begin
        // extension restarts in full on each clearing of the zone
        // a directional first channel must not leave an extension behind
        if (occ_i[c] || no_timers)
          ext_run_q <= 1'b0; // R14 R23
        else if (fall)
        begin
          ext_run_q <= ext_q[c] != 8'h00;
          ext_cnt_q <= ext_q[c]; // R23
          if (ext_q[c] == 8'h00 && disc_act)
            disc_q <= 1'b1;
        end
        else if (ext_run_q && tick)
        begin
          ext_cnt_q <= ext_cnt_q - 8'h01;
          if (ext_cnt_q == 8'h01)
          begin
            ext_run_q <= 1'b0;
            if (disc_act)
              disc_q <= 1'b1; // R19
          end
        end
        if (!green[c] || !cfg[`CFG_DISC_EN])
          disc_q <= 1'b0; // R19 R20
        // vehicle counter: once per entry, wraps
        if (cnt_rst)
          cnt_q <= 16'h0000; // R06
        else if (rise)
          cnt_q <= cnt_q + 16'h0001; // R04 R25
        // display: plain binary low three digits, upper part flagged by bit 15 alternates
        if (tick)
        begin
          alt_q <= (alt_q == `DISP_ALT_TICKS - 1) ? 4'h0 : alt_q + 4'h1;
          if (alt_q == `DISP_ALT_TICKS - 1)
            alt_hi_q <= !alt_hi_q;
        end
        if (!cfg[`CFG_CNT_DISP])
          disp_q <= 16'h0000; // R03
        else if (cnt_q <= `DISP_LOW_MAX || !alt_hi_q)
          disp_q <= {4'h0, lo3[11:0]}; // R05
        else
          disp_q <= {1'b1, 8'h00, hi2[6:0]}; // R05
        // green compensation: 500 units of 0.0001 percent over 15 s
        if (!cfg[`CFG_GREEN_COMP] || !green[c])
        begin
          comp_q <= 16'h0000; // R02
          comp_tick_q <= 8'h00;
        end
        else if (call_o[c] && tick && comp_tick_q != `COMP_TICKS)
        begin
          comp_tick_q <= comp_tick_q + 8'h01;
          comp_q <= comp_quo[15:0]; // R01
        end
      end
    end
    assign base_call[c] = any_fail[c] || (!disc_q &&
      (occ_i[c] || (use_ext && ext_run_q))); // R21 R22
    assign cnt_all[16*c +: 16] = cnt_q;
    assign disp_all[16*c +: 16] = disp_q;
    assign comp_all[16*c +: 16] = comp_q;
  end
endgenerate

// registered so the panel value never glitches between the two channels
always @(posedge mclk_i)
begin
  if (!nrst_i)
    comp_o <= 16'h0000;
  else if (ce_i)
    comp_o <= (comp_view0 > comp_view1) ? comp_view0 : comp_view1;
end

reg [1:0] call_sel;
always @*
begin
  call_sel = base_call;
  if (tcp_mode)
  begin
    // and-pairing: a call needs both loops, a failed loop still calls
    if (occ_i == 2'h3)
      call_sel = {2{&base_call}} | any_fail; // R10
    else
      call_sel = any_fail; // R10
  end
  else if (dir_mode)
    call_sel = (base_call & ~first_q) | (any_fail & first_q); // R12 R13
end
assign call_o = call_sel;

////////////////////////////////////////////////////////////////////////////////
// register read

always @(posedge mclk_i)
begin
  if (!nrst_i)
    rdata_o <= 16'h0000;
  else if (ce_i)
  begin
    rdata_o <= 16'h0000;
    if (rd_i)
      case (addr_i)
        `REG_CTRL: rdata_o <= {13'h0, ctrl_q};
        // the counter reset request is write-only, so it always reads off
        `REG_CH0_CFG: rdata_o <= {5'h0, cfg_q[0][10:3], 1'b0, cfg_q[0][1:0]}; // R07
        `REG_CH1_CFG: rdata_o <= {5'h0, cfg_q[1][10:3], 1'b0, cfg_q[1][1:0]}; // R07
        `REG_CH0_EXT: rdata_o <= {8'h0, ext_q[0]};
        `REG_CH1_EXT: rdata_o <= {8'h0, ext_q[1]};
        `REG_CH0_CNT: rdata_o <= cnt_view0;
        `REG_CH1_CNT: rdata_o <= cnt_view1;
        `REG_STATUS: rdata_o <= {7'h0, audible_o, pending_o, fail_o, call_o, occ_i};
        `REG_DISP0: rdata_o <= disp_view0;
        `REG_DISP1: rdata_o <= disp_view1;
        `REG_COMP0: rdata_o <= comp_view0;
        `REG_COMP1: rdata_o <= comp_view1;
        default: rdata_o <= 16'h0000;
      endcase
  end
end

endmodule // loop_opts

// >>> src/loop_opts_map.vh
// constants for the two-channel loop detector option logic
`ifndef LOOP_OPTS_MAP_VH
`define LOOP_OPTS_MAP_VH
// register indices
`define REG_CTRL 4'h0
`define REG_CH0_CFG 4'h1
`define REG_CH1_CFG 4'h2
`define REG_CH0_EXT 4'h3
`define REG_CH1_EXT 4'h4
`define REG_CH0_CNT 4'h5
`define REG_CH1_CNT 4'h6
`define REG_STATUS 4'h7
`define REG_DISP0 4'h8
`define REG_DISP1 4'h9
`define REG_COMP0 4'ha
`define REG_COMP1 4'hb
// ctrl fields
`define CTRL_COMMON_FAIL 0
`define CTRL_THIRD_CAR 1
`define CTRL_DIRECTIONAL 2
// per channel cfg fields
`define CFG_GREEN_COMP 0
`define CFG_CNT_DISP 1
`define CFG_CNT_RST 2
`define CFG_AUDIBLE 3
`define CFG_DISC_EN 4
`define CFG_DISC_SUB 5
`define CFG_LANE_LSB 8
`define CFG_LANE_MSB 10
`define LANE_RESET 3'h1
`define LANE_MAX 3'h5
// timing
`define TICK_MS 100
`define CLK_MHZ 100
`define TICK_CYCLES (`TICK_MS * 1000 * `CLK_MHZ)
`define COMP_S 15
`define COMP_TICKS (`COMP_S * 1000 / `TICK_MS)
`define COMP_TOTAL 16'h01f4
`define AUD_MIN 15
`define AUD_TICKS (`AUD_MIN * 60 * 1000 / `TICK_MS)
`define DISP_ALT_TICKS 10
`define DISP_LOW_MAX 16'h03e7
`endif

// >>> tb/loop_opts_checker.sv
// checker for the loop detector option logic
`timescale 1ns/100ps
module loop_opts_checker #(
  parameter TICK_CYCLES = 4,
  parameter AUD_TICKS = 5
) (
  // clock, reset, register port
  input wire mclk_i,
  input wire nrst_i,
  input wire ce_i,
  input wire [3:0] addr_i,
  input wire [15:0] wdata_i,
  input wire wr_i,
  input wire rd_i,
  input wire [15:0] rdata_o,
  // loops and controller
  input wire [1:0] occ_i,
  input wire [1:0] fail_i,
  input wire [1:0] green_n_i,
  input wire [1:0] call_o,
  input wire [1:0] fail_o,
  input wire [1:0] pending_o,
  input wire audible_o,
  input wire [15:0] comp_o
);
  // slack covers the tick phase and the write latency
  localparam AUD_LIM = AUD_TICKS * TICK_CYCLES + TICK_CYCLES + 4;
  reg [2:0] ctrl_q;
  reg f0_q;
  reg [31:0] aud_q;
  ////////////////////////////////////////
  always @(posedge mclk_i)
  begin
    if (!nrst_i)
    begin
      ctrl_q <= 3'h0;
      f0_q <= 1'b0;
      aud_q <= 32'h0;
    end
    else if (ce_i)
    begin
      if (wr_i && addr_i == 4'h0)
        ctrl_q <= wdata_i[2:0];
      // held while both occupied, so it names the first channel
      if (occ_i != 2'b11)
        f0_q <= (occ_i == 2'b01);
      if (wr_i && (addr_i == 4'h1 || addr_i == 4'h2) && wdata_i[3])
        aud_q <= 32'h0;
      else if (aud_q <= AUD_LIM)
        aud_q <= aud_q + 32'h1;
    end
  end
  ////////////////////////////////////////
  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (!nrst_i);
  property p_fail_own; (fail_o & fail_i) == fail_i; endproperty
  a_fail_own: assert property (p_fail_own) else $error("fail not shown");
  property p_fail_com; ctrl_q[0] && fail_i != 2'b00 |-> fail_o == 2'b11; endproperty
  a_fail_com: assert property (p_fail_com) else $error("fail not shared");
  property p_third; ctrl_q[1] && !ctrl_q[2] && fail_i == 2'b00 |-> call_o[0] == call_o[1];
  endproperty
  a_third: assert property (p_third) else $error("calls not paired");
  property p_pend_clr; (ctrl_q[1] || ctrl_q[2]) && occ_i == 2'b11 && $past(occ_i) == 2'b11
    |-> pending_o == 2'b00; endproperty
  a_pend_clr: assert property (p_pend_clr) else $error("pending stuck");
  property p_dir_first; ctrl_q[2] && fail_i == 2'b00 && occ_i == 2'b01
    && $past(occ_i) == 2'b01 && $past(occ_i, 2) == 2'b00 |-> pending_o == 2'b01 && !call_o[0];
  endproperty
  a_dir_first: assert property (p_dir_first) else $error("first not pending");
  property p_dir_last; ctrl_q[2] && fail_i == 2'b00 && f0_q && $past(occ_i) == 2'b11
    && occ_i == 2'b10 |-> call_o == 2'b10; endproperty
  a_dir_last: assert property (p_dir_last) else $error("last not calling");
  property p_aud; audible_o |-> aud_q <= AUD_LIM; endproperty
  a_aud: assert property (p_aud) else $error("audible too long");
  property p_rst_rd; rd_i && (addr_i == 4'h1 || addr_i == 4'h2) |=> rdata_o[2] == 1'b0;
  endproperty
  a_rst_rd: assert property (p_rst_rd) else $error("reset bit shown");
  property p_comp; comp_o <= 16'h01f4; endproperty
  a_comp: assert property (p_comp) else $error("comp too deep");
endmodule // loop_opts_checker
bind loop_opts loop_opts_checker #(.TICK_CYCLES(TICK_CYCLES), .AUD_TICKS(AUD_TICKS))
  i_loop_opts_checker (.*);

// >>> tb/ctrl_model.sv
// traffic controller model driving the phase green pins
`timescale 1ns/100ps
module ctrl_model (
  // clock and green request
  input wire mclk_i,
  input wire [1:0] green_rq_i,
  // phase green pins, low is green
  output reg [1:0] green_n_o
);
  initial green_n_o = 2'b11;
  always @(posedge mclk_i)
    green_n_o <= ~green_rq_i;
endmodule // ctrl_model

// >>> tb/tb_loop_opts.sv
// self-checking bench for the loop detector option logic
`timescale 1ns/100ps
module tb_loop_opts;
  reg mclk_i = 1'b0;
  reg nrst_i = 1'b0;
  reg ce_i = 1'b1;
  reg [3:0] addr_i = 4'h0;
  reg [15:0] wdata_i = 16'h0;
  reg wr_i = 1'b0;
  reg rd_i = 1'b0;
  reg [1:0] occ_i = 2'b00;
  reg [1:0] fail_i = 2'b00;
  reg [1:0] green_rq = 2'b00;
  wire [15:0] rdata_o, comp_o;
  wire [1:0] green_n_i, call_o, fail_o, pending_o;
  wire audible_o;
  integer miscompares = 0;
  integer n_compared = 0;
  integer cyc = 0;
  integer i;
  reg [15:0] rv;
  reg [1:0] seen;
`define CHK(a, b) begin n_compared = n_compared + 1; if ((a) !== (b)) begin \
  miscompares = miscompares + 1; \
  $display("wrong value at %0t: %h, expected %h", $time, a, b); end end
  always #5 mclk_i = ~mclk_i;
  // short ticks keep the timed options within a few hundred cycles
  loop_opts #(.TICK_CYCLES(4), .AUD_TICKS(5)) i_loop_opts (.*);
  ctrl_model i_ctrl_model (.mclk_i(mclk_i), .green_rq_i(green_rq), .green_n_o(green_n_i));
  ////////////////////////////////////////
  task stop_test;
  begin
    $display("compared %0d, wrong %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  end
  endtask
  always @(posedge mclk_i)
  begin
    cyc = cyc + 1;
    if (cyc == 20000)
    begin
      miscompares = miscompares + 1;
      stop_test;
    end
  end
  task tick(input integer n);
  begin
    repeat (n) @(posedge mclk_i);
    #1;
  end
  endtask
  task wr(input [3:0] a, input [15:0] d);
  begin
    @(posedge mclk_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    tick(1);
    wr_i <= 1'b0;
  end
  endtask
  task rd(input [3:0] a);
  begin
    @(posedge mclk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    tick(1);
    rd_i <= 1'b0;
    rv = rdata_o;
  end
  endtask
  // green needs a model edge and two sync edges before it counts
  task drv(input [1:0] o, input [1:0] g, input [1:0] f);
  begin
    @(posedge mclk_i);
    occ_i <= o;
    green_rq <= g;
    fail_i <= f;
    tick(4);
  end
  endtask
  task pulse(input integer n);
  begin
    repeat (n)
    begin
      @(posedge mclk_i);
      occ_i <= 2'b01;
      @(posedge mclk_i);
      occ_i <= 2'b00;
    end
    tick(2);
  end
  endtask
  task scan(input [15:0] a, input [15:0] b);
  begin
    seen = 2'b00;
    repeat (30)
    begin
      rd(4'h8);
      `CHK(rv === a || rv === b, 1'b1)
      seen = seen | {rv === b, rv === a};
    end
    `CHK(seen, 2'b11)
  end
  endtask
  ////////////////////////////////////////
  initial
  begin
    tick(4);
    nrst_i <= 1'b1;
    rd(4'h1);
    `CHK(rv, 16'h0100)
    for (i = 1; i < 6; i = i + 1)
    begin
      wr(4'h1, {5'h0, i[2:0], 8'h00});
      rd(4'h1);
      `CHK(rv, {5'h0, i[2:0], 8'h00})
    end
    wr(4'h1, 16'h0600);
    rd(4'h1);
    `CHK(rv, 16'h0500)
    rd(4'hf);
    `CHK(rv, 16'h0000)
    $display("lane test done");
    wr(4'h1, 16'h0102);
    pulse(3);
    rd(4'h5);
    `CHK(rv, 16'h0003)
    pulse(996);
    scan(16'h03e7, 16'h03e7);
    pulse(1);
    rd(4'h5);
    `CHK(rv, 16'h03e8)
    scan(16'h0000, 16'h8001);
    wr(4'h1, 16'h0100);
    rd(4'h8);
    `CHK(rv, 16'h0000)
    wr(4'h1, 16'h0106);
    rd(4'h5);
    `CHK(rv, 16'h0000)
    $display("count test done");
    drv(2'b00, 2'b00, 2'b01);
    `CHK(fail_o, 2'b01)
    wr(4'h0, 16'h0001);
    `CHK(fail_o, 2'b11)
    drv(2'b00, 2'b00, 2'b00);
    wr(4'h0, 16'h0002);
    drv(2'b01, 2'b00, 2'b00);
    `CHK({call_o, pending_o}, 4'b0001)
    drv(2'b11, 2'b00, 2'b00);
    `CHK({call_o, pending_o}, 4'b1100)
    drv(2'b00, 2'b00, 2'b00);
    wr(4'h3, 16'h0020);
    wr(4'h4, 16'h0003);
    wr(4'h0, 16'h0004);
    drv(2'b01, 2'b00, 2'b00);
    `CHK({call_o, pending_o}, 4'b0001)
    drv(2'b11, 2'b00, 2'b00);
    drv(2'b10, 2'b00, 2'b00);
    `CHK(call_o, 2'b10)
    drv(2'b00, 2'b00, 2'b00);
    `CHK(call_o[0], 1'b0)
    `CHK(call_o[1], 1'b1)
    wr(4'h0, 16'h0000);
    $display("fail and pair test done");
    wr(4'h1, 16'h0108);
    drv(2'b01, 2'b00, 2'b00);
    `CHK(audible_o, 1'b1)
    wr(4'h2, 16'h0108);
    rd(4'h1);
    `CHK(rv[3], 1'b0)
    drv(2'b10, 2'b00, 2'b00);
    `CHK(audible_o, 1'b1)
    tick(30);
    `CHK(audible_o, 1'b0)
    $display("audible test done");
    wr(4'h3, 16'h0003);
    wr(4'h1, 16'h0110);
    drv(2'b01, 2'b01, 2'b00);
    drv(2'b00, 2'b01, 2'b00);
    `CHK(call_o[0], 1'b1)
    tick(14);
    drv(2'b01, 2'b01, 2'b00);
    `CHK(call_o[0], 1'b0)
    drv(2'b01, 2'b00, 2'b00);
    `CHK(call_o[0], 1'b1)
    drv(2'b00, 2'b00, 2'b00);
    wr(4'h1, 16'h0130);
    drv(2'b01, 2'b01, 2'b00);
    drv(2'b00, 2'b01, 2'b00);
    `CHK(call_o[0], 1'b0)
    $display("disconnect test done");
    wr(4'h1, 16'h0101);
    drv(2'b01, 2'b01, 2'b00);
    tick(620);
    `CHK(comp_o, 16'h01f4)
    rd(4'hb);
    `CHK(rv, 16'h0000)
    $display("compensation test done");
    stop_test;
  end
endmodule // tb_loop_opts
